// File: verilog/ssi_reader_defs.svh
// Operation
// - word length 1..15 or 24..25 bits; exactly that many bits per readout.
// - position word read as plain binary or Gray per code format setting.
// - a wait period is inserted after every serial clock edge.
// - wait count zero adds no wait; 3 us bit time, about 333 kHz.
// - wait counts 0..F accepted; from count 1 to F the rate falls from ~185 kHz to ~45 kHz.
// - bit time is 3 us, plus for counts 1..F twice (0.6 us plus count times 0.6 us).
// - readouts up to 25 bits; slowest full readout about 555 us.
// - end-of-word line check runs only when monitoring is enabled.
// - data must be low one bit time after last bit, else error 12.
// - clock driven as differential pair, data received as differential pair.
`ifndef SSI_READER_DEFS_SVH
`define SSI_READER_DEFS_SVH
`define ADDR_CTRL        8'h00
`define ADDR_CFG         8'h04
`define ADDR_POSITION    8'h08
`define ADDR_STATUS      8'h0c
`define ADDR_INT_STATUS  8'h10
`define ADDR_INT_MASK    8'h14
`define CTRL_START_BIT   0
`define CTRL_GRAY_BIT    1
`define CTRL_MON_BIT     2
`define CFG_LEN_LSB      0
`define CFG_WAIT_LSB     8
`define INT_DONE_BIT     0
`define INT_ENC_ERR_BIT  1
`define INT_CFG_ERR_BIT  2
`define RST_WORD_LEN     5'h18
`define RST_WAIT_COUNT   4'h0
`define ERR_CODE_ENCODER 8'h0c
`define CLK_PERIOD_NS    20
`define BASE_BIT_NS      3000
`define STRETCH_STEP_NS  600
`define BASE_HALF_CYC    ((`BASE_BIT_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRETCH_CYC      ((`STRETCH_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: verilog/ssi_reader_pkg.sv
package ssi_reader_pkg;
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_LOW   = 2'b01,
		ST_HIGH  = 2'b10,
		ST_CHECK = 2'b11
	} link_state_type;
endpackage : ssi_reader_pkg

// File: verilog/ssi_encoder_reader.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "ssi_reader_defs.svh"
module ssi_encoder_reader #(
	parameter int TIMER_W = 11
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             encoder_clock_pos,
	output logic             encoder_clock_neg,
	input  wire logic        encoder_data_pos,
	input  wire logic        encoder_data_neg,
	output logic             irq
);
	import ssi_reader_pkg::*;

	localparam logic [TIMER_W-1:0] HALF_BASE = TIMER_W'(`BASE_HALF_CYC);
	localparam logic [TIMER_W-1:0] STEP      = TIMER_W'(`STRETCH_CYC);

	function automatic logic [31:0] gray_to_bin(input logic [31:0] g);
		logic [31:0] b;
		b = '0;
		b[31] = g[31];
		for (int i = 30; i >= 0; i--)
		begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : gray_to_bin

	function automatic logic len_ok(input logic [4:0] n);
		return (n >= 5'h01 && n <= 5'h0f) || n == 5'h18 || n == 5'h19;
	endfunction : len_ok

	// half of a bit time: base half plus the per-edge wait
	function automatic logic [TIMER_W-1:0] half_time(input logic [3:0] n);
		logic [TIMER_W-1:0] extra;
		extra = '0;
		if (n != 4'h0)
		begin
			extra = TIMER_W'(STEP * (TIMER_W'(n) + TIMER_W'(1)));
		end
		return HALF_BASE + extra;
	endfunction : half_time

	logic           gray_r;
	logic           mon_r;
	logic [4:0]     len_r;
	logic [3:0]     wait_r;
	logic [31:0]    pos_r;
	logic [7:0]     err_code_r;
	logic [2:0]     int_stat_r;
	logic [2:0]     int_mask_r;
	logic           start_r;
	logic           aw_held_r;
	logic           w_held_r;
	logic [7:0]     waddr_r;
	logic [31:0]    wdata_r;
	logic [3:0]     wstrb_r;
	logic           dpos_meta_r;
	logic           dpos_sync_r;
	logic           dneg_meta_r;
	logic           dneg_sync_r;
	link_state_type state_r;
	logic [TIMER_W-1:0] timer_r;
	logic [TIMER_W-1:0] half_r;
	logic [4:0]     bits_r;
	logic [31:0]    shift_r;
	logic           ev_done;
	logic           ev_enc_err;
	logic           ev_cfg_err;
	logic           do_write;
	logic           wr_hit;
	logic           data_bit;

	assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_hit   = waddr_r == `ADDR_CTRL || waddr_r == `ADDR_CFG
		|| waddr_r == `ADDR_INT_STATUS || waddr_r == `ADDR_INT_MASK;
	// receiver decision: the positive leg must be high and the negative low
	assign data_bit = dpos_sync_r && !dneg_sync_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r     <= 1'b0;
			waddr_r       <= 8'h00;
			s_axi_awready <= 1'b0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_r     <= 1'b1;
			waddr_r       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		else if (do_write)
		begin
			aw_held_r     <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held_r && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_r     <= 1'b0;
			wdata_r      <= 32'h0;
			wstrb_r      <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_r     <= 1'b1;
			wdata_r      <= s_axi_wdata;
			wstrb_r      <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		else if (do_write)
		begin
			w_held_r     <= 1'b0;
		end
		else
		begin
			s_axi_wready <= !w_held_r && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// configuration; a wait change while busy takes effect at the next start, length, gray and monitor changes at once
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gray_r     <= 1'b0;
			mon_r      <= 1'b0;
			len_r      <= `RST_WORD_LEN;
			wait_r     <= `RST_WAIT_COUNT;
			int_mask_r <= 3'h0;
			start_r    <= 1'b0;
		end
		else
		begin
			start_r <= 1'b0;
			if (do_write && wstrb_r[0])
			begin
				unique case (waddr_r)
					`ADDR_CTRL:
					begin
						start_r <= wdata_r[`CTRL_START_BIT];
						gray_r  <= wdata_r[`CTRL_GRAY_BIT];
						mon_r   <= wdata_r[`CTRL_MON_BIT];
					end
					`ADDR_CFG:
					begin
						len_r <= wdata_r[`CFG_LEN_LSB +: 5];
					end
					`ADDR_INT_MASK:
					begin
						int_mask_r <= wdata_r[2:0];
					end
					default:
					begin
					end
				endcase
			end
			if (do_write && wstrb_r[1] && waddr_r == `ADDR_CFG)
			begin
				wait_r <= wdata_r[`CFG_WAIT_LSB +: 4];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			int_stat_r <= 3'h0;
			irq        <= 1'b0;
		end
		else
		begin
			// a new event wins over a simultaneous write-one-to-clear
			int_stat_r <= (int_stat_r & ~((do_write && wstrb_r[0]
				&& waddr_r == `ADDR_INT_STATUS) ? wdata_r[2:0] : 3'h0))
				| {ev_cfg_err, ev_enc_err, ev_done};
			irq <= |(int_stat_r & int_mask_r);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'b00;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'b00;
			unique case (s_axi_araddr)
				`ADDR_CTRL:       s_axi_rdata <= {29'h0, mon_r, gray_r, 1'b0};
				`ADDR_CFG:        s_axi_rdata <= {20'h0, wait_r, 3'h0, len_r};
				`ADDR_POSITION:   s_axi_rdata <= pos_r;
				`ADDR_STATUS:     s_axi_rdata <= {16'h0, err_code_r, 7'h0,
					state_r != ST_IDLE};
				`ADDR_INT_STATUS: s_axi_rdata <= {29'h0, int_stat_r};
				`ADDR_INT_MASK:   s_axi_rdata <= {29'h0, int_mask_r};
				default:
				begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
		else
		begin
			s_axi_arready <= 1'b1;
		end
	end

	// data pins come from the encoder's domain
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dpos_meta_r <= 1'b0;
			dpos_sync_r <= 1'b0;
			dneg_meta_r <= 1'b1;
			dneg_sync_r <= 1'b1;
		end
		else
		begin
			dpos_meta_r <= encoder_data_pos;
			dpos_sync_r <= dpos_meta_r;
			dneg_meta_r <= encoder_data_neg;
			dneg_sync_r <= dneg_meta_r;
		end
	end

	// sampling at the end of the high half leaves a full half bit for the
	// encoder to settle, which covers the two-flop synchroniser delay
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r           <= ST_IDLE;
			timer_r           <= '0;
			half_r            <= HALF_BASE;
			bits_r            <= 5'h0;
			shift_r           <= 32'h0;
			pos_r             <= 32'h0;
			err_code_r        <= 8'h0;
			encoder_clock_pos <= 1'b1;
			encoder_clock_neg <= 1'b0;
			ev_done           <= 1'b0;
			ev_enc_err        <= 1'b0;
			ev_cfg_err        <= 1'b0;
		end
		else
		begin
			ev_done    <= 1'b0;
			ev_enc_err <= 1'b0;
			ev_cfg_err <= 1'b0;
			if (timer_r != '0)
			begin
				timer_r <= timer_r - TIMER_W'(1);
			end
			unique case (state_r)
				ST_IDLE:
				begin
					encoder_clock_pos <= 1'b1;
					encoder_clock_neg <= 1'b0;
					if (start_r && !len_ok(len_r))
					begin
						ev_cfg_err <= 1'b1;
					end
					else if (start_r)
					begin
						// first falling edge makes the encoder latch
						encoder_clock_pos <= 1'b0;
						encoder_clock_neg <= 1'b1;
						half_r  <= half_time(wait_r);
						timer_r <= half_time(wait_r) - TIMER_W'(1);
						bits_r  <= 5'h0;
						shift_r <= 32'h0;
						state_r <= ST_LOW;
					end
				end
				ST_LOW:
				begin
					if (timer_r == '0)
					begin
						encoder_clock_pos <= 1'b1;
						encoder_clock_neg <= 1'b0;
						timer_r <= half_r - TIMER_W'(1);
						state_r <= ST_HIGH;
					end
				end
				ST_HIGH:
				begin
					if (timer_r == '0)
					begin
						shift_r <= {shift_r[30:0], data_bit};
						bits_r  <= bits_r + 5'h1;
						if (bits_r + 5'h1 == len_r)
						begin
							if (mon_r)
							begin
								timer_r <= TIMER_W'({half_r, 1'b0} - 1);
								state_r <= ST_CHECK;
							end
							else
							begin
								pos_r   <= gray_r ? gray_to_bin({shift_r[30:0], data_bit})
									: {shift_r[30:0], data_bit};
								ev_done <= 1'b1;
								state_r <= ST_IDLE;
							end
						end
						else
						begin
							encoder_clock_pos <= 1'b0;
							encoder_clock_neg <= 1'b1;
							timer_r <= half_r - TIMER_W'(1);
							state_r <= ST_LOW;
						end
					end
				end
				ST_CHECK:
				begin
					if (timer_r == '0)
					begin
						pos_r   <= gray_r ? gray_to_bin(shift_r) : shift_r;
						ev_done <= 1'b1;
						state_r <= ST_IDLE;
						if (data_bit)
						begin
							err_code_r <= `ERR_CODE_ENCODER;
							ev_enc_err <= 1'b1;
						end
						else
						begin
							err_code_r <= 8'h0;
						end
					end
				end
			endcase
		end
	end
endmodule : ssi_encoder_reader

// File: sim/ssi_reader_monitor.sv
`timescale 1ns/1ps
module ssi_reader_monitor (
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic		s_axi_bvalid,
	input wire logic		s_axi_bready,
	input wire logic		s_axi_arvalid,
	input wire logic		s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic		s_axi_rvalid,
	input wire logic		s_axi_rready,
	input wire logic		encoder_clock_pos,
	input wire logic		encoder_clock_neg,
	input wire logic		irq
);
	logic [9:0]	cnt_r;
	logic		prev_r;
	logic		half_ok;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// low half is 75 at wait 0, else 75 + 30 * (wait + 1)
	assign half_ok = cnt_r == 10'h04b || (cnt_r >= 10'h087 && cnt_r <= 10'h22b
		&& (cnt_r - 10'h04b) % 10'h01e == 10'h000);
	always_ff @(posedge aclk)
	begin
		prev_r <= encoder_clock_pos;
		if (!aresetn || encoder_clock_pos != prev_r)
			cnt_r <= 10'h001;
		else if (cnt_r != 10'h3ff)
			cnt_r <= cnt_r + 10'h001;
	end
	AST_CLK_DIFF: assert property (encoder_clock_neg == !encoder_clock_pos)
		else $error("clock legs differ");
	AST_IDLE_HIGH: assert property ($rose(aresetn) |-> encoder_clock_pos && !irq)
		else $error("clock not idle");
	AST_LOW_HALF: assert property ($rose(encoder_clock_pos) |-> half_ok)
		else $error("bad low half");
	AST_LOW_MIN: assert property ($fell(encoder_clock_pos) |-> !encoder_clock_pos [*8])
		else $error("short low half");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read dropped");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read late");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read overlap");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write reply dropped");
	cover property ($rose(irq));
	cover property ($rose(encoder_clock_pos) && cnt_r == 10'h04b);
	cover property ($rose(encoder_clock_pos) && cnt_r == 10'h087);
endmodule : ssi_reader_monitor
bind ssi_encoder_reader ssi_reader_monitor i_mon (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.encoder_clock_pos, .encoder_clock_neg, .irq);

// File: sim/ssi_encoder_model.sv
`timescale 1ns/1ps
module ssi_encoder_model (
	input wire logic		clock_pos,
	input wire logic		clock_neg,
	input wire logic [31:0]	word,
	input wire logic [5:0]	len,
	input wire logic		bad_end,
	output logic			data_pos,
	output logic			data_neg
);
	wire		clk = clock_pos & ~clock_neg;
	logic [31:0]	sh;
	int		left = 0;
	realtime	t_fall = 0;
	assign data_neg = ~data_pos;
	initial data_pos = 1'b1;
	always @(negedge clk)
	begin
		t_fall = $realtime;
		if (left == 0)
		begin
			sh = word << (32 - len);
			left = len;
		end
	end
	always @(posedge clk)
		if (left > 0)
		begin
			data_pos = sh[31];
			sh = sh << 1;
			left--;
			// monoflop settles a quarter bit after the design has sampled
			if (left == 0)
				data_pos <= #(1.5 * ($realtime - t_fall)) bad_end;
		end
endmodule : ssi_encoder_model

// File: sim/ssi_encoder_reader_tb.sv
`timescale 1ns/1ps
module ssi_encoder_reader_tb;
	logic		aclk = 1'b0;
	logic		aresetn = 1'b0;
	logic [7:0]	s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]	s_axi_wdata = 32'h0, word = 32'h0, s_axi_rdata, rdat;
	logic		s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic		s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, bad = 1'b0;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic		encoder_clock_pos, encoder_clock_neg, encoder_data_pos, encoder_data_neg, irq;
	logic [5:0]	len = 6'h00;
	int		n_fail = 0, tests_run = 0, falls = 0, i = 0;
	logic [5:0]	lens [5] = '{6'h01, 6'h0d, 6'h0f, 6'h18, 6'h19};
	logic [31:0]	vals [5] = '{32'h1, 32'h1abc, 32'h5a5a, 32'hc3a5f0, 32'h1234567};
	always #10 aclk = ~aclk;
	always @(negedge encoder_clock_pos) falls++;
	ssi_encoder_reader i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .encoder_clock_pos,
		.encoder_clock_neg, .encoder_data_pos, .encoder_data_neg, .irq);
	ssi_encoder_model i_enc (.clock_pos(encoder_clock_pos), .clock_neg(encoder_clock_neg),
		.word, .len, .bad_end(bad), .data_pos(encoder_data_pos), .data_neg(encoder_data_neg));
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task tmo;
		if (i >= 99)
		begin
			n_fail++;
			end_of_test();
		end
	endtask : tmo
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		i = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			i++;
		end
		while (s_axi_bvalid !== 1'b1 && i < 99);
		s_axi_bready <= 1'b0;
		tmo();
		chk(s_axi_bresp, er);
	endtask : wr
	task rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		i = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			i++;
		end
		while (s_axi_rvalid !== 1'b1 && i < 99);
		rdat = s_axi_rdata;
		s_axi_rready <= 1'b0;
		tmo();
		chk(s_axi_rresp, er);
	endtask : rd
	task rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		rd(a, er);
		chk(rdat, e);
	endtask : rc
	// gray bit set: encoder sends the gray form, readback must be binary
	task run(input logic [5:0] l, input logic [3:0] w, input logic [2:0] c, input logic [31:0] v);
		len <= l;
		word <= c[1] ? v ^ (v >> 1) : v;
		falls = 0;
		wr(8'h04, {20'h0, w, 3'h0, l[4:0]}, 2'b00);
		wr(8'h00, {29'h0, c}, 2'b00);
		for (i = 0; i < 99 && irq !== 1'b1; i++)
			repeat (400) @(posedge aclk);
		tmo();
	endtask : run
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rc(8'h04, 32'h18, 2'b00);
		rc(8'h20, 32'h0, 2'b10);
		wr(8'h20, 32'h1, 2'b10);
		wr(8'h14, 32'h7, 2'b00);
		$display("test registers done");
		for (int k = 0; k < 5; k++)
		begin
			run(lens[k], k[3:0], {1'b1, k[0], 1'b1}, vals[k]);
			rc(8'h08, vals[k], 2'b00);
			rc(8'h0c, 32'h0, 2'b00);
			chk(falls, lens[k]);
			chk(encoder_clock_pos, 1'b1);
			wr(8'h10, 32'h7, 2'b00);
			@(posedge aclk);
			chk(irq, 1'b0);
			$display("test readout %0d done", k);
		end
		bad <= 1'b1;
		run(6'h05, 4'h0, 3'b101, 32'h15);
		rc(8'h0c, 32'h0c00, 2'b00);
		rd(8'h10, 2'b00);
		chk(rdat[1], 1'b1);
		wr(8'h14, 32'h0, 2'b00);
		@(posedge aclk);
		chk(irq, 1'b0);
		wr(8'h14, 32'h7, 2'b00);
		@(posedge aclk);
		chk(irq, 1'b1);
		wr(8'h10, 32'h7, 2'b00);
		run(6'h05, 4'h0, 3'b001, 32'h15);
		rd(8'h10, 2'b00);
		chk(rdat[1], 1'b0);
		wr(8'h10, 32'h7, 2'b00);
		$display("test monitor done");
		run(6'h10, 4'h0, 3'b001, 32'h0);
		rd(8'h10, 2'b00);
		chk(rdat[2], 1'b1);
		chk(falls, 0);
		$display("test length done");
		end_of_test();
	end
endmodule : ssi_encoder_reader_tb
